// ==== decoder_status_map.svh ====
// Purpose: Offsets, field positions and reset values of the status and debug-halt registers.
// Assumes: Byte addresses on the 20-bit configuration bus, one 32-bit word per register.
// Notes:   Definitions only; included by bare name.
`ifndef DECODER_STATUS_MAP_SVH
`define DECODER_STATUS_MAP_SVH

// ==========================================================================
// Register offsets
`define CFG_ADDR_W          20
`define OFS_EMU_CTRL        20'h00070
`define OFS_DEC_STATUS      20'h0006c

// ==========================================================================
// Emulation control fields and reset value
`define EMU_FREE_BIT        0
`define EMU_SOFT_BIT        1
`define EMU_CTRL_RST        2'h0

// ==========================================================================
// Status word field positions
`define ST_TOP_STATE_HI     27
`define ST_TOP_STATE_LO     24
`define ST_CRC_PASS         23
`define ST_SNR_HI           22
`define ST_SNR_LO           21
`define ST_ITER_HI          20
`define ST_ITER_LO          16
`define ST_ACT_STATE_HI     15
`define ST_ACT_STATE_LO     12
`define ST_ACT_HALF         11
`define ST_DBG_HALTED       10
`define ST_WAIT_HI          9
`define ST_WAIT_LO          3
`define ST_INPUT_ERR        2
`define ST_DEC_ACTIVE       1
`define ST_RESET_VAL        32'h00000000

`endif

// ==== decoder_status_pkg.sv ====
// Purpose: Types shared by the status and debug-halt register logic.
// Assumes: Offsets and field positions live in decoder_status_map.svh.
// Notes:   Nothing here is imported; users write the package name.
package decoder_status_pkg;

    // States of the emulation halt controller.
    typedef enum logic [1:0] {
        HALT_RUN,
        HALT_AT_HALF,
        HALT_AT_DECODE
    } halt_state_t;

endpackage : decoder_status_pkg

// ==== sync_3ff.sv ====
// Purpose: Three-flop synchroniser for a level from another clock domain.
// Assumes: One clock, asynchronous active-high reset.
// Notes:   The output changes only when the second and third stages agree.
`timescale 1ns/10ps

module sync_3ff (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    output logic      level_o
);

    logic stage1_q;
    logic stage2_q;
    logic stage3_q;

    // ======================================================================
    // Synchroniser chain; the first stage feeds only the second.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
            stage3_q <= 1'b0;
            level_o  <= 1'b0;
        end else begin
            stage1_q <= async_i;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            if (stage2_q == stage3_q) begin
                level_o <= stage3_q;
            end
        end
    end

endmodule : sync_3ff

// ==== emu_halt_ctrl.sv ====
// Purpose: Decides when the decoder stops for a debugger emulation halt.
// Assumes: Halt request already synchronised; end markers are one-cycle pulses.
// Notes:   Free-run overrides the halt-point choice entirely.
`timescale 1ns/10ps

module emu_halt_ctrl (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic emu_req_i,
    input  wire logic free_run_i,
    input  wire logic halt_point_i,
    input  wire logic end_of_half_i,
    input  wire logic end_of_decode_i,
    output logic      halted_o,
    output logic      halted_at_half_o
);

    decoder_status_pkg::halt_state_t state_q;
    decoder_status_pkg::halt_state_t state_d;

    logic arm_w;
    logic stop_half_w;
    logic stop_decode_w;

    // A halt is pending only without free-run; half end wins when allowed.
    assign arm_w         = emu_req_i & ~free_run_i;                     // R20
    assign stop_half_w   = arm_w & ~halt_point_i & end_of_half_i;       // R21
    assign stop_decode_w = arm_w & end_of_decode_i & ~stop_half_w;      // R21

    // ======================================================================
    // Next-state logic; the halt ends when the request drops or free-run sets.
    always_comb begin
        state_d = state_q;
        case (state_q)
            decoder_status_pkg::HALT_RUN: begin
                if (stop_half_w) begin
                    state_d = decoder_status_pkg::HALT_AT_HALF;
                end else if (stop_decode_w) begin
                    state_d = decoder_status_pkg::HALT_AT_DECODE;
                end
            end
            decoder_status_pkg::HALT_AT_HALF,
            decoder_status_pkg::HALT_AT_DECODE: begin
                if (!arm_w) begin
                    state_d = decoder_status_pkg::HALT_RUN;          // R7
                end
            end
            default: state_d = decoder_status_pkg::HALT_RUN;
        endcase
    end

    // State and registered outputs.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q          <= decoder_status_pkg::HALT_RUN;
            halted_o         <= 1'b0;
            halted_at_half_o <= 1'b0;
        end else begin
            state_q          <= state_d;
            halted_o         <= (state_d != decoder_status_pkg::HALT_RUN);
            halted_at_half_o <= (state_d == decoder_status_pkg::HALT_AT_HALF);
        end
    end

    // ======================================================================
    // Checks on the halt decision.
    chk_free_no_halt: assert property ( // R20
        @(posedge mclk_i) disable iff (rst_i)
        free_run_i |=> ##1 !halted_o)
        else $error("Halt seen while free-run was set.");

    chk_point_decode_only: assert property ( // R21
        @(posedge mclk_i) disable iff (rst_i)
        (!halted_o && halt_point_i && end_of_half_i && !end_of_decode_i) |=> !halted_o)
        else $error("Halt at half end although halt point selects decode end.");

    chk_half_priority: assert property ( // R21
        @(posedge mclk_i) disable iff (rst_i)
        (state_q == decoder_status_pkg::HALT_RUN && arm_w && !halt_point_i
         && end_of_half_i) |=> halted_o && halted_at_half_o)
        else $error("Half end did not take the halt.");

    chk_halt_release: assert property ( // R7
        @(posedge mclk_i) disable iff (rst_i)
        (halted_o && !emu_req_i) |=> ##[0:1] !halted_o)
        else $error("Halt flag stayed after the request dropped.");

    cov_halt_half: cover property (
        @(posedge mclk_i) disable iff (rst_i) $rose(halted_at_half_o));

    cov_halt_decode: cover property (
        @(posedge mclk_i) disable iff (rst_i)
        $rose(halted_o) && !halted_at_half_o);

endmodule : emu_halt_ctrl

// ==== decoder_status_regs.sv ====
// Overview of operation
// R1 - Status bits 31:28 and 0 read zero.
// R2 - Bits 27:24 show top-level control state.
// R3 - Bit 23 shows block check passed.
// R4 - Bits 22:21 give tested half and result.
// R5 - Bits 20:16 iteration, 15:12 active state.
// R6 - Bit 11 shows active decoding half.
// R7 - Bit 10 set while halted by debugger.
// R8 - Software ignores halt bit with halt point.
// R9 - Bit 9: waiting for output parameters read.
// R10 - Bit 8: waiting for decisions read.
// R11 - Bit 7: waiting for first extrinsic read.
// R12 - Bit 6: waiting for second extrinsic load.
// R13 - Bit 5: waiting for systematic/parity load.
// R14 - Bit 4: waiting for interleaver load.
// R15 - Bit 3: waiting for configuration words.
// R16 - Bit 2 flags input configuration error.
// R17 - Bit 1 set unless decoder state zero.
// R18 - Emulation control word at address 0x00070.
// R19 - Memories stay accessible while emulation halted.
// R20 - Free-run ignores debugger halt entirely.
// R21 - Halt point selects decode or half end.
// R22 - Status resets to zero, read-only.
//
// Purpose: Status word and emulation control word of the decoder coprocessor.
// Assumes: Single clock; halt request from the debugger arrives asynchronously.
// Notes:   Reads answer one cycle after the request; unmapped reads give zero.
`timescale 1ns/10ps
`include "decoder_status_map.svh"

module decoder_status_regs (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // Configuration bus.
    input  wire logic        cfg_sel_i,
    input  wire logic        cfg_wr_i,
    input  wire logic [19:0] cfg_addr_i,
    input  wire logic [31:0] cfg_wdata_i,
    output logic [31:0]      cfg_rdata_o,
    output logic             cfg_rvalid_o,
    // Decoder core state.
    input  wire logic [3:0]  top_state_i,
    input  wire logic        crc_pass_i,
    input  wire logic        noise_ratio_half_i,
    input  wire logic        noise_ratio_pass_i,
    input  wire logic [4:0]  current_iteration_i,
    input  wire logic [3:0]  active_state_i,
    input  wire logic        active_half_i,
    input  wire logic        wait_out_params_read_i,
    input  wire logic        wait_decisions_read_i,
    input  wire logic        wait_extr0_read_i,
    input  wire logic        wait_extr1_load_i,
    input  wire logic        wait_sys_parity_load_i,
    input  wire logic        wait_interleaver_load_i,
    input  wire logic        wait_config_load_i,
    input  wire logic        input_error_i,
    input  wire logic [3:0]  decoder_state_i,
    input  wire logic        end_of_half_i,
    input  wire logic        end_of_decode_i,
    // Debugger halt request.
    input  wire logic        cpu_emu_halt_i,
    // Host memory access path.
    input  wire logic        hmem_req_i,
    input  wire logic        hmem_wr_i,
    output logic             hmem_req_o,
    output logic             hmem_wr_o,
    // Halt to the decoder core.
    output logic             core_halt_o,
    output logic             halted_at_half_o
);

    logic [1:0]  emu_ctrl_q;
    logic [31:0] status_q;
    logic [31:0] status_d;
    logic        emu_req_w;
    logic        halted_w;
    logic        half_w;
    logic        hit_emu_w;
    logic        hit_status_w;
    logic        rd_w;
    logic        wr_emu_w;
    logic [31:0] rdata_d;
    logic        decoder_active_w;
    logic [6:0]  wait_flags_w;

    // ======================================================================
    // Debugger halt request synchroniser.
    sync_3ff u_emu_sync (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .async_i (cpu_emu_halt_i),
        .level_o (emu_req_w)
    );

    // ======================================================================
    // Halt decision from the free-run and halt-point bits.
    emu_halt_ctrl u_halt (
        .mclk_i           (mclk_i),
        .rst_i            (rst_i),
        .emu_req_i        (emu_req_w),
        .free_run_i       (emu_ctrl_q[`EMU_FREE_BIT]),
        .halt_point_i     (emu_ctrl_q[`EMU_SOFT_BIT]),
        .end_of_half_i    (end_of_half_i),
        .end_of_decode_i  (end_of_decode_i),
        .halted_o         (halted_w),
        .halted_at_half_o (half_w)
    );

    // ======================================================================
    // Address decode; only the control word accepts writes.
    assign hit_emu_w    = (cfg_addr_i == `OFS_EMU_CTRL);                // R18
    assign hit_status_w = (cfg_addr_i == `OFS_DEC_STATUS);
    assign rd_w         = cfg_sel_i & ~cfg_wr_i;
    assign wr_emu_w     = cfg_sel_i & cfg_wr_i & hit_emu_w;             // R18

    // Waiting flags in bit order 9 down to 3.
    assign wait_flags_w = {wait_out_params_read_i,                      // R9
                           wait_decisions_read_i,                       // R10
                           wait_extr0_read_i,                           // R11
                           wait_extr1_load_i,                           // R12
                           wait_sys_parity_load_i,                      // R13
                           wait_interleaver_load_i,                     // R14
                           wait_config_load_i};                         // R15

    // Decoder reported active in any state other than zero.
    assign decoder_active_w = (decoder_state_i != 4'h0);                // R17

    // Status word assembly; reserved bits tie to zero.
    always_comb begin
        status_d = `ST_RESET_VAL;                                       // R1
        status_d[`ST_TOP_STATE_HI:`ST_TOP_STATE_LO] = top_state_i;      // R2
        status_d[`ST_CRC_PASS] = crc_pass_i;                            // R3
        status_d[`ST_SNR_HI]   = noise_ratio_half_i;                    // R4
        status_d[`ST_SNR_LO]   = noise_ratio_pass_i;                    // R4
        status_d[`ST_ITER_HI:`ST_ITER_LO] = current_iteration_i;        // R5
        status_d[`ST_ACT_STATE_HI:`ST_ACT_STATE_LO] = active_state_i;   // R5
        status_d[`ST_ACT_HALF]   = active_half_i;                       // R6
        status_d[`ST_DBG_HALTED] = halted_w;                            // R7
        status_d[`ST_WAIT_HI:`ST_WAIT_LO] = wait_flags_w;
        status_d[`ST_INPUT_ERR]  = input_error_i;                       // R16
        status_d[`ST_DEC_ACTIVE] = decoder_active_w;                    // R17
    end

    // Read data mux; unmapped addresses read as zero.
    assign rdata_d = hit_emu_w    ? {30'h00000000, emu_ctrl_q} :
                     hit_status_w ? status_q : 32'h00000000;

    // ======================================================================
    // Status capture; software cannot write it.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            status_q <= `ST_RESET_VAL;                                  // R22
        end else begin
            status_q <= status_d;                                       // R22
        end
    end

    // Emulation control word; upper bits are dropped on write.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            emu_ctrl_q <= `EMU_CTRL_RST;
        end else if (wr_emu_w) begin
            emu_ctrl_q <= cfg_wdata_i[1:0];                             // R18
        end
    end

    // Read answer one cycle after the request.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_rdata_o  <= 32'h00000000;
            cfg_rvalid_o <= 1'b0;
        end else begin
            cfg_rvalid_o <= rd_w;
            cfg_rdata_o  <= rd_w ? rdata_d : 32'h00000000;
        end
    end

    // Host memory path is never gated by the halt.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            hmem_req_o <= 1'b0;
            hmem_wr_o  <= 1'b0;
        end else begin
            hmem_req_o <= hmem_req_i;                                   // R19
            hmem_wr_o  <= hmem_wr_i;                                    // R19
        end
    end

    // Halt outputs to the core.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            core_halt_o      <= 1'b0;
            halted_at_half_o <= 1'b0;
        end else begin
            core_halt_o      <= halted_w;                               // R7
            halted_at_half_o <= half_w;
        end
    end

    // ======================================================================
    // Checks on the register bank.
    chk_reserved_zero: assert property ( // R1
        @(posedge mclk_i) disable iff (rst_i)
        status_q[31:28] == 4'h0 && status_q[0] == 1'b0)
        else $error("Reserved status bits not zero.");

    chk_top_state: assert property ( // R2
        @(posedge mclk_i) disable iff (rst_i)
        ##1 status_q[27:24] == $past(top_state_i))
        else $error("Top state field does not follow the core.");

    chk_crc_pass: assert property ( // R3
        @(posedge mclk_i) disable iff (rst_i)
        crc_pass_i |=> status_q[23])
        else $error("Check pass bit not set.");

    chk_noise_field: assert property ( // R4
        @(posedge mclk_i) disable iff (rst_i)
        ##1 status_q[22:21] == $past({noise_ratio_half_i, noise_ratio_pass_i}))
        else $error("Noise ratio field wrong.");

    chk_iter_state: assert property ( // R5
        @(posedge mclk_i) disable iff (rst_i)
        ##1 status_q[20:12] == $past({current_iteration_i, active_state_i}))
        else $error("Iteration or active state field wrong.");

    chk_active_half: assert property ( // R6
        @(posedge mclk_i) disable iff (rst_i)
        ##1 status_q[11] == $past(active_half_i))
        else $error("Active half bit wrong.");

    chk_halt_bit: assert property ( // R7
        @(posedge mclk_i) disable iff (rst_i)
        status_q[10] == core_halt_o)
        else $error("Halt status bit disagrees with core halt.");

    chk_wait_flags: assert property ( // R9 R10 R11 R12 R13 R14 R15
        @(posedge mclk_i) disable iff (rst_i)
        ##1 status_q[9:3] == $past(wait_flags_w))
        else $error("Waiting flags wrong.");

    chk_input_error: assert property ( // R16
        @(posedge mclk_i) disable iff (rst_i)
        ##1 status_q[2] == $past(input_error_i))
        else $error("Input error bit wrong.");

    chk_dec_active: assert property ( // R17
        @(posedge mclk_i) disable iff (rst_i)
        ##1 status_q[1] == ($past(decoder_state_i) != 4'h0))
        else $error("Decoder active bit wrong.");

    chk_emu_write: assert property ( // R18
        @(posedge mclk_i) disable iff (rst_i)
        (cfg_sel_i && cfg_wr_i && cfg_addr_i == 20'h00070)
        |=> emu_ctrl_q == $past(cfg_wdata_i[1:0]))
        else $error("Control word write not taken at its address.");

    chk_emu_readback: assert property ( // R18
        @(posedge mclk_i) disable iff (rst_i)
        (rd_w && hit_emu_w) |=> cfg_rvalid_o && cfg_rdata_o == {30'h0, $past(emu_ctrl_q)})
        else $error("Control word read back wrong.");

    chk_mem_access: assert property ( // R19
        @(posedge mclk_i) disable iff (rst_i)
        (core_halt_o && hmem_req_i) |=> hmem_req_o)
        else $error("Host memory access blocked during halt.");

    chk_status_ro: assert property ( // R22
        @(posedge mclk_i) disable iff (rst_i)
        (cfg_sel_i && cfg_wr_i && hit_status_w)
        |=> status_q == $past(status_d) && $stable(emu_ctrl_q))
        else $error("Status word changed by a write.");

    chk_read_idle: assert property ( // R18
        @(posedge mclk_i) disable iff (rst_i)
        !rd_w
        |=> !cfg_rvalid_o && cfg_rdata_o == 32'h0)
        else $error("Read answer outside a read.");

    chk_status_read: assert property ( // R22
        @(posedge mclk_i) disable iff (rst_i)
        (rd_w && hit_status_w)
        |=> cfg_rvalid_o && cfg_rdata_o == $past(status_q))
        else $error("Status read data wrong.");

    chk_ctrl_hold: assert property ( // R18
        @(posedge mclk_i) disable iff (rst_i)
        !(cfg_sel_i && cfg_wr_i && cfg_addr_i == 20'h00070)
        |=> $stable(emu_ctrl_q))
        else $error("Control word changed without a write.");

    chk_unmapped_zero: assert property ( // R18
        @(posedge mclk_i) disable iff (rst_i)
        (rd_w && !hit_emu_w && !hit_status_w)
        |=> cfg_rdata_o == 32'h0)
        else $error("Unmapped read not zero.");

    cov_status_read: cover property (
        @(posedge mclk_i) disable iff (rst_i) rd_w && hit_status_w);

    cov_halted_read: cover property (
        @(posedge mclk_i) disable iff (rst_i) core_halt_o && rd_w && hit_status_w);

    cov_free_run: cover property (
        @(posedge mclk_i) disable iff (rst_i) emu_ctrl_q[0] && emu_req_w);

endmodule : decoder_status_regs

// ==== host_cfg_model.sv ====
// Purpose: Host processor model that drives the configuration bus.
// Assumes: One word per access; a read is answered by a one-cycle rvalid.
// Notes:   Released address and data are inverted so stale values never match.
`timescale 1ns/10ps

module host_cfg_model (
    input  wire logic        mclk_i,
    input  wire logic [31:0] cfg_rdata_i,
    input  wire logic        cfg_rvalid_i,
    output logic             cfg_sel_o,
    output logic             cfg_wr_o,
    output logic [19:0]      cfg_addr_o,
    output logic [31:0]      cfg_wdata_o
);
    // ==========================================================================
    // Bus cycles
    // The bus is idle from time zero.
    initial begin
        cfg_sel_o   = 1'b0;
        cfg_wr_o    = 1'b0;
        cfg_addr_o  = 20'h00000;
        cfg_wdata_o = 32'h00000000;
    end

    // Holds a request for one edge, then inverts the released lines.
    task automatic put(input logic w, input logic [19:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        cfg_sel_o   <= 1'b1;
        cfg_wr_o    <= w;
        cfg_addr_o  <= a;
        cfg_wdata_o <= d;
        @(posedge mclk_i);
        cfg_sel_o   <= 1'b0;
        cfg_addr_o  <= ~a;
        cfg_wdata_o <= ~d;
    endtask : put

    // Writes one word; a write has no answer.
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        put(1'b1, a, d);
    endtask : wr

    // Reads one word, waiting a bounded time for the answer.
    task automatic rd(input logic [19:0] a, output logic [31:0] d);
        int n;
        n = 0;
        put(1'b0, a, 32'h00000000);
        #1;
        while (cfg_rvalid_i !== 1'b1 && n < 8) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        d = (n < 8) ? cfg_rdata_i : 32'hxxxxxxxx;
    endtask : rd
endmodule : host_cfg_model

// ==== test_turbo_decoder_status_debug_regs.sv ====
// Purpose: Self-checking bench for the status word and emulation control word.
// Assumes: Core levels sit in core_q at their status bit places.
// Notes:   The halt request passes a synchroniser, so waits allow for its latency.
`timescale 1ns/10ps
`include "decoder_status_map.svh"

module test_turbo_decoder_status_debug_regs;
    // ==========================================================================
    // Clock, reset and stimulus
    logic        mclk_i = 1'b0;
    logic        rst_i  = 1'b1;
    logic [31:0] core_q = 32'h00000000;
    logic [3:0]  dstate_q = 4'h0;
    logic        half_q = 1'b0;
    logic        dec_q = 1'b0;
    logic        emu_q = 1'b0;
    logic        mreq_q = 1'b0;
    logic        mwr_q = 1'b0;
    logic        sel, wr, rvalid, mreq_o, mwr_o, halt_o, at_half_o;
    logic [19:0] addr;
    logic [31:0] wdata, rdata, v;
    int          miscompares = 0;
    int          checks = 0;

    // The clock toggles every half period of 2.5 ns.
    always #2.5 mclk_i = ~mclk_i;

    // ==========================================================================
    // Design and host
    decoder_status_regs dut (.mclk_i(mclk_i), .rst_i(rst_i), .cfg_sel_i(sel), .cfg_wr_i(wr),
        .cfg_addr_i(addr), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
        .top_state_i(core_q[27:24]), .crc_pass_i(core_q[23]), .noise_ratio_half_i(core_q[22]),
        .noise_ratio_pass_i(core_q[21]), .current_iteration_i(core_q[20:16]),
        .active_state_i(core_q[15:12]), .active_half_i(core_q[11]),
        .wait_out_params_read_i(core_q[9]), .wait_decisions_read_i(core_q[8]),
        .wait_extr0_read_i(core_q[7]), .wait_extr1_load_i(core_q[6]),
        .wait_sys_parity_load_i(core_q[5]), .wait_interleaver_load_i(core_q[4]),
        .wait_config_load_i(core_q[3]), .input_error_i(core_q[2]), .decoder_state_i(dstate_q),
        .end_of_half_i(half_q), .end_of_decode_i(dec_q), .cpu_emu_halt_i(emu_q),
        .hmem_req_i(mreq_q), .hmem_wr_i(mwr_q), .hmem_req_o(mreq_o), .hmem_wr_o(mwr_o),
        .core_halt_o(halt_o), .halted_at_half_o(at_half_o));

    host_cfg_model host (.mclk_i(mclk_i), .cfg_rdata_i(rdata), .cfg_rvalid_i(rvalid),
        .cfg_sel_o(sel), .cfg_wr_o(wr), .cfg_addr_o(addr), .cfg_wdata_o(wdata));

    // ==========================================================================
    // Shared tasks
    // Compares a seen value with the expected one.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    // Waits a number of rising edges.
    task automatic wt(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : wt

    // Gives one end-of-half and/or end-of-decode pulse, then waits for the halt to land.
    task automatic pulse(input logic h, input logic d);
        @(posedge mclk_i);
        half_q <= h;
        dec_q  <= d;
        @(posedge mclk_i);
        half_q <= 1'b0;
        dec_q  <= 1'b0;
        wt(4);
        #1;
    endtask : pulse

    // Sets the control word and raises the synchronised halt request.
    task automatic arm(input logic [31:0] ctrl);
        host.wr(`OFS_EMU_CTRL, ctrl);
        @(posedge mclk_i);
        emu_q <= 1'b1;
        wt(7);
    endtask : arm

    // Drops the halt request and checks that the core resumes.
    task automatic disarm;
        @(posedge mclk_i);
        emu_q <= 1'b0;
        wt(12);
        #1;
        chk({31'h0, halt_o}, 32'h0);
    endtask : disarm

    // ==========================================================================
    // Scenarios
    // Reset values of both words and the halt output.
    task automatic t_reset;
        host.rd(`OFS_DEC_STATUS, v);
        chk(v, 32'h00000000);
        host.rd(`OFS_EMU_CTRL, v);
        chk(v, 32'h00000000);
        chk({31'h0, halt_o}, 32'h0);
        $display("t_reset done");
    endtask : t_reset

    // Control word keeps two bits; status ignores writes and an unmapped place reads zero.
    task automatic t_ctrl;
        host.wr(`OFS_EMU_CTRL, 32'hffffffff);
        host.rd(`OFS_EMU_CTRL, v);
        chk(v, 32'h00000003);
        host.wr(`OFS_DEC_STATUS, 32'hffffffff);
        host.rd(`OFS_DEC_STATUS, v);
        chk(v, 32'h00000000);
        host.rd(20'h00074, v);
        chk(v, 32'h00000000);
        $display("t_ctrl done");
    endtask : t_ctrl

    // Every field, with free-run set so the halt bit is defined.
    task automatic t_fields;
        logic [31:0] pat [3];
        logic [3:0]  st [3];
        pat = '{32'hffffffff, 32'h55555555, 32'haaaaaaaa};
        st  = '{4'h8, 4'h1, 4'h0};
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk_i);
            core_q   <= pat[i];
            dstate_q <= st[i];
            wt(3);
            host.rd(`OFS_DEC_STATUS, v);
            chk(v & 32'hfffff800, {4'h0, pat[i][27:11], 11'h000});
            chk(v & 32'h000003f8, {22'h0, pat[i][9:3], 3'h0});
            chk(v & 32'h00000407, {21'h0, 8'h00, pat[i][2], |st[i], 1'b0});
        end
        $display("t_fields done");
    endtask : t_fields

    // Half end wins over decode end; host memory path stays open.
    task automatic t_halt_half;
        arm(32'h00000000);
        pulse(1'b1, 1'b1);
        chk({30'h0, halt_o, at_half_o}, 32'h3);
        host.rd(`OFS_DEC_STATUS, v);
        chk(v & 32'h00000400, 32'h00000400);
        @(posedge mclk_i);
        mreq_q <= 1'b1;
        mwr_q  <= 1'b1;
        wt(2);
        #1;
        chk({30'h0, mreq_o, mwr_o}, 32'h3);
        disarm();
        $display("t_halt_half done");
    endtask : t_halt_half

    // Halt point set: a half end is passed by, a decode end halts.
    task automatic t_halt_decode;
        arm(32'h00000002);
        pulse(1'b1, 1'b0);
        chk({31'h0, halt_o}, 32'h0);
        pulse(1'b0, 1'b1);
        chk({30'h0, halt_o, at_half_o}, 32'h2);
        disarm();
        $display("t_halt_decode done");
    endtask : t_halt_decode

    // Free-run ignores the halt request at both end markers.
    task automatic t_free;
        arm(32'h00000003);
        pulse(1'b1, 1'b1);
        chk({31'h0, halt_o}, 32'h0);
        host.rd(`OFS_DEC_STATUS, v);
        chk(v & 32'h00000400, 32'h00000000);
        disarm();
        $display("t_free done");
    endtask : t_free

    // ==========================================================================
    // Run control
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    // Main sequence after six reset cycles.
    initial begin
        wt(6);
        rst_i <= 1'b0;
        t_reset();
        t_ctrl();
        t_fields();
        t_halt_half();
        t_halt_decode();
        t_free();
        test_done();
    end

    // Ends a hung run as a failure.
    initial begin
        #20000;
        miscompares++;
        test_done();
    end
endmodule : test_turbo_decoder_status_debug_regs
